// ==== logic/mps_pkg.sv ====
// constants and types shared by the microprogram sequencer
package mps_pkg;

    // ************************************************************
    // address layout
    // ************************************************************
    localparam int ADDR_W   = 9;
    localparam int ROW_W    = 5;
    localparam int COL_W    = 4;
    localparam int COL_LSB  = 0;
    localparam int ROW_LSB  = 4;
    localparam int CTRL_W   = 7;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
    localparam logic [3:0]        ISE_COL    = 4'hf;

    // ************************************************************
    // bus register map
    // ************************************************************
    localparam int BUS_AW = 4;
    localparam logic [BUS_AW-1:0] REG_CONTROL = 4'h0;
    localparam logic [BUS_AW-1:0] REG_STATUS  = 4'h4;
    localparam int CTRL_RUN_BIT   = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int STS_CARRY_BIT  = 9;
    localparam int STS_ZERO_BIT   = 10;
    localparam int STS_SAMPLE_BIT = 11;
    localparam int STS_LATCH_LSB  = 12;

    // ************************************************************
    // jump functions and flag functions
    // ************************************************************
    typedef enum logic [3:0] {
        JUMP_IN_COLUMN         = 4'h0,
        JUMP_ROW_ZERO          = 4'h1,
        JUMP_IN_ROW            = 4'h2,
        JUMP_GROUP_DRIVE_LATCH = 4'h3,
        JUMP_TEST_SAMPLE       = 4'h4,
        JUMP_TEST_CARRY        = 4'h5,
        JUMP_TEST_ZERO         = 4'h6,
        JUMP_TEST_LATCH_ALL    = 4'h7,
        JUMP_TEST_LATCH_HI     = 4'h8,
        JUMP_TEST_LATCH_LO     = 4'h9,
        JUMP_TEST_PRIMARY      = 4'ha
    } mps_jump_t;

    typedef enum logic [1:0] {
        FLAGS_BOTH_LOAD = 2'h0,
        ZERO_FLAG_LOAD  = 2'h1,
        CARRY_FLAG_LOAD = 2'h2,
        FLAGS_HOLD      = 2'h3
    } mps_flag_in_t;

    typedef enum logic [1:0] {
        FLAGOUT_CONST_LOW  = 2'h0,
        FLAGOUT_CARRY      = 2'h1,
        FLAGOUT_ZERO_FLAG  = 2'h2,
        FLAGOUT_CONST_HIGH = 2'h3
    } mps_flag_out_t;

    typedef struct packed {
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } mps_addr_t;

    typedef struct packed {
        mps_flag_out_t outSel;
        mps_flag_in_t  inSel;
    } mps_flag_ctrl_t;

endpackage

// ==== logic/mps_sequencer.sv ====
// microprogram sequencer: next address, program latch, flags, bus slave
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps

// Function
// - next address comes from the held address plus control bits, stored at the edge.
// - two to five control bits pick the function, the rest give row or column.
// - jump in column keeps the column, row from control bits 0 to 4.
// - jump to row zero forces row zero, column from control bits 0 to 3.
// - jump in row keeps the row, column from control bits 0 to 3.
// - group jump keeps column and row bits 7-8, sets low rows, enables latch outputs.
// - zero test acts like the carry test but uses the zero flag.
// - sample test picks column 2/3 or 10/11 by address bit 3.
// - latch-all test picks a row in the group, latch forms the column.
// - upper-latch test uses latch bits 2-3 for columns 4 to 7.
// - lower-latch test picks a high row, latch bits 0-1 give columns 12 to 15.
// - primary test picks one of four rows, primary bus forms the column.
// - primary test captures the secondary bus into the program latch.
// - flag input is sampled and loaded into the selected flags at the same edge.
// - flag input functions load both, zero only, carry only or neither.
// - flag output is constant 0, carry, zero or constant 1.
// - load puts primary bus in bits 0-3, secondary in 4-7, clears bit 8.
// - interrupt strobe enable is high for jump to row zero, column 15.
// - row override releases the row lines and leaves the address register alone.
// - load overrides jumps but not latch drive, capture, strobe or flags.
// - output enable drives address, latch and flag outputs, else released.
// - the address is a five-bit row over a four-bit column.
module mps_sequencer
    import mps_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 clkEn,
    // microinstruction control
    input  wire logic [CTRL_W-1:0]    nextAddrCtrl,
    input  wire mps_flag_ctrl_t       flagCtrl,
    input  wire logic                 loadOverride,
    input  wire logic [3:0]           primaryInstrBus,
    input  wire logic [3:0]           secondaryInstrBus,
    input  wire logic                 flagIn,
    // output enables
    input  wire logic                 outEn,
    input  wire logic                 rowOverride_n,
    // microprogram address and side outputs
    output mps_addr_t                 microAddr,
    output logic                      microColOe,
    output logic                      microRowOe,
    output logic [2:0]                programLatchOut,
    output logic                      programLatchOe,
    output logic                      flagOut,
    output logic                      flagOutOe,
    output logic                      interruptStrobeEn,
    // avalon-mm slave
    input  wire logic [BUS_AW-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest
);

    // ************************************************************
    // state
    // ************************************************************
    mps_addr_t  addr_ff;
    mps_addr_t  nxt_addr;
    logic [3:0] latch_ff;
    logic       carry_ff;
    logic       zero_ff;
    logic       sample_ff;
    logic       run_ff;
    logic       ack_ff;
    logic [31:0] rdata_ff;
    mps_jump_t  jumpSel;
    logic [4:0] d;
    logic [4:0] m;
    logic       busReq;
    logic       busTake;

    assign d = nextAddrCtrl[4:0];
    assign m = addr_ff.row;

    // ************************************************************
    // function decode
    // ************************************************************
    function automatic mps_jump_t decodeJump(input logic [CTRL_W-1:0] ac);
        if (ac[6:5] == 2'b00)
            return JUMP_IN_COLUMN;
        else if (ac[6:4] == 3'b010)
            return JUMP_ROW_ZERO;
        else if (ac[6:4] == 3'b011)
            return JUMP_IN_ROW;
        else if (ac[6:4] == 3'b100)
            return JUMP_TEST_SAMPLE;
        else if (ac[6:3] == 4'b1010)
            return JUMP_TEST_CARRY;
        else if (ac[6:3] == 4'b1011)
            return JUMP_TEST_ZERO;
        else if (ac[6:3] == 4'b1100)
            return JUMP_TEST_LATCH_ALL;
        else if (ac[6:3] == 4'b1101)
            return JUMP_TEST_LATCH_HI;
        else if (ac[6:3] == 4'b1110)
            return JUMP_GROUP_DRIVE_LATCH;
        else if (ac[6:2] == 5'b11110)
            return JUMP_TEST_PRIMARY;
        else
            return JUMP_TEST_LATCH_LO;
    endfunction

    assign jumpSel = decodeJump(nextAddrCtrl);

    // ************************************************************
    // next address
    // ************************************************************
    always_comb begin
        nxt_addr = addr_ff;
        case (jumpSel)
            JUMP_IN_COLUMN: begin
                nxt_addr.row = d;
            end
            JUMP_ROW_ZERO: begin
                nxt_addr.row = 5'h00;
                nxt_addr.col = d[3:0];
            end
            JUMP_IN_ROW: begin
                nxt_addr.col = d[3:0];
            end
            JUMP_GROUP_DRIVE_LATCH: begin
                nxt_addr.row = {m[4:3], d[2:0]};
            end
            JUMP_TEST_SAMPLE: begin
                nxt_addr.row = {m[4], d[3:0]};
                nxt_addr.col = {addr_ff.col[3], 2'b01, sample_ff};
            end
            JUMP_TEST_CARRY: begin
                nxt_addr.row = {m[4:3], d[2:0]};
                nxt_addr.col = {addr_ff.col[3], 2'b01, carry_ff};
            end
            JUMP_TEST_ZERO: begin
                nxt_addr.row = {m[4:3], d[2:0]};
                nxt_addr.col = {addr_ff.col[3], 2'b01, zero_ff};
            end
            JUMP_TEST_LATCH_ALL: begin
                nxt_addr.row = {m[4:3], d[2:0]};
                nxt_addr.col = latch_ff;
            end
            JUMP_TEST_LATCH_HI: begin
                nxt_addr.row = {m[4:3], d[2:0]};
                nxt_addr.col = {2'b01, latch_ff[3:2]};
            end
            JUMP_TEST_LATCH_LO: begin
                nxt_addr.row = {m[4:3], 1'b1, d[1:0]};
                nxt_addr.col = {2'b11, latch_ff[1:0]};
            end
            JUMP_TEST_PRIMARY: begin
                nxt_addr.row = {m[4:2], d[1:0]};
                nxt_addr.col = primaryInstrBus;
            end
            default: begin
                nxt_addr = addr_ff;
            end
        endcase
        if (loadOverride)
            nxt_addr = {1'b0, secondaryInstrBus, primaryInstrBus};
    end

    // the register holds its own row whatever an interrupt unit drives outside
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            addr_ff <= ADDR_RESET;
        else if (clkEn && run_ff)
            addr_ff <= nxt_addr;
    end

    // ************************************************************
    // program latch
    // ************************************************************
    // capture is not gated by load, so a load cycle can still fill the latch
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            latch_ff <= 4'h0;
        else if (clkEn && run_ff && jumpSel == JUMP_TEST_PRIMARY)
            latch_ff <= secondaryInstrBus;
    end

    // ************************************************************
    // flags
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            sample_ff <= 1'b0;
        else if (clkEn)
            sample_ff <= flagIn;
    end

    // flags take the value sampled during the low phase, i.e. at this edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            carry_ff <= 1'b0;
            zero_ff  <= 1'b0;
        end else if (clkEn && run_ff) begin
            if (flagCtrl.inSel == FLAGS_BOTH_LOAD || flagCtrl.inSel == CARRY_FLAG_LOAD)
                carry_ff <= flagIn;
            if (flagCtrl.inSel == FLAGS_BOTH_LOAD || flagCtrl.inSel == ZERO_FLAG_LOAD)
                zero_ff <= flagIn;
        end
    end

    always_comb begin
        case (flagCtrl.outSel)
            FLAGOUT_CONST_LOW:  flagOut = 1'b0;
            FLAGOUT_CARRY:      flagOut = carry_ff;
            FLAGOUT_ZERO_FLAG:  flagOut = zero_ff;
            default:            flagOut = 1'b1;
        endcase
    end

    // ************************************************************
    // pins
    // ************************************************************
    assign microAddr         = addr_ff;
    assign microColOe        = outEn;
    assign microRowOe        = outEn & rowOverride_n;
    assign flagOutOe         = outEn;
    assign programLatchOut   = latch_ff[2:0];
    assign programLatchOe    = outEn && jumpSel == JUMP_GROUP_DRIVE_LATCH;
    assign interruptStrobeEn = jumpSel == JUMP_ROW_ZERO && d[3:0] == ISE_COL;

    // ************************************************************
    // bus slave
    // ************************************************************
    // one wait cycle per access keeps read data registered
    assign busReq          = avs_read | avs_write;
    assign busTake         = busReq & ack_ff;
    assign avs_waitrequest = busReq & ~ack_ff;
    assign avs_readdata    = rdata_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            ack_ff <= 1'b0;
        else if (clkEn)
            ack_ff <= busReq & ~ack_ff;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            rdata_ff <= 32'h0;
        else if (clkEn && avs_read && !ack_ff) begin
            rdata_ff <= 32'h0;
            if (avs_address == REG_CONTROL)
                rdata_ff[CTRL_RUN_BIT] <= run_ff;
            else if (avs_address == REG_STATUS) begin
                rdata_ff[ADDR_W-1:0]           <= addr_ff;
                rdata_ff[STS_CARRY_BIT]        <= carry_ff;
                rdata_ff[STS_ZERO_BIT]         <= zero_ff;
                rdata_ff[STS_SAMPLE_BIT]       <= sample_ff;
                rdata_ff[STS_LATCH_LSB +: 4]   <= latch_ff;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            run_ff <= CTRL_RUN_RESET;
        else if (clkEn && busTake && avs_write && avs_address == REG_CONTROL)
            run_ff <= avs_writedata[CTRL_RUN_BIT];
    end

endmodule // mps_sequencer

// ==== testbench/mps_sequencer_props.sv ====
// assertions on the sequencer ports
`timescale 1ns/1ps
module mps_sequencer_props
    import mps_pkg::*;
(
    // clock, reset and controls
    input wire logic               sys_clk, reset_n, clkEn, loadOverride, flagIn, outEn, rowOverride_n,
    input wire logic [CTRL_W-1:0]  nextAddrCtrl,
    input wire mps_flag_ctrl_t     flagCtrl,
    input wire logic [3:0]         primaryInstrBus, secondaryInstrBus,
    // sequencer outputs
    input wire mps_addr_t          microAddr,
    input wire logic               microColOe, microRowOe, programLatchOe, flagOut, flagOutOe,
    input wire logic               interruptStrobeEn,
    input wire logic [2:0]         programLatchOut,
    // bus
    input wire logic [BUS_AW-1:0]  avs_address,
    input wire logic               avs_read, avs_write, avs_waitrequest,
    input wire logic [31:0]        avs_writedata, avs_readdata
);
    // ************
    // properties
    // ************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic jmp;
    assign jmp = clkEn && !loadOverride;

    strobe_dec_a: assert property (interruptStrobeEn == (nextAddrCtrl == 7'h2f))
        else $error("strobe enable does not follow the jump code");
    load_addr_a: assert property (clkEn && loadOverride |=>
        microAddr == {1'b0, $past(secondaryInstrBus), $past(primaryInstrBus)}) else $error("load address wrong");
    row_zero_a: assert property (jmp && nextAddrCtrl[6:4] == 3'b010 |=>
        microAddr == {5'h00, $past(nextAddrCtrl[3:0])}) else $error("row zero jump wrong");
    in_col_a: assert property (jmp && nextAddrCtrl[6:5] == 2'b00 |=>
        microAddr.row == $past(nextAddrCtrl[4:0]) && $stable(microAddr.col)) else $error("column jump wrong");
    in_row_a: assert property (jmp && nextAddrCtrl[6:4] == 3'b011 |=>
        $stable(microAddr.row) && microAddr.col == $past(nextAddrCtrl[3:0])) else $error("row jump wrong");
    latch_oe_a: assert property (programLatchOe == (outEn && nextAddrCtrl[6:3] == 4'b1110))
        else $error("latch drive wrong");
    addr_oe_a: assert property (microRowOe == (outEn && rowOverride_n) && microColOe == outEn)
        else $error("address drive wrong");
    flag_const_a: assert property (flagCtrl.outSel[0] == flagCtrl.outSel[1] |->
        flagOut == flagCtrl.outSel[0]) else $error("constant flag output wrong");
    bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest && clkEn |=> !avs_waitrequest)
        else $error("bus answer late");

    cover property (interruptStrobeEn && clkEn);
    cover property (clkEn && loadOverride && nextAddrCtrl[6:2] == 5'b11110);
    cover property (avs_read && !avs_waitrequest);
endmodule // mps_sequencer_props

bind mps_sequencer mps_sequencer_props i_props (.*);

// ==== testbench/mps_far_side.sv ====
// far side: interrupt unit taking the row lines, and the memory row bus
`timescale 1ns/1ps
module mps_far_side
    import mps_pkg::*;
#(
    parameter logic [4:0] IRQ_ROW = 5'h15
)
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // sequencer side
    input  wire mps_addr_t  microAddr,
    input  wire logic       microRowOe,
    input  wire logic       interruptStrobeEn,
    input  wire logic       irqReq,
    output logic            rowOverride_n = 1'b1,
    output logic [4:0]      memRow
);
    logic [4:0] lastRow_ff;
    // take the row lines for one cycle after a strobe with a request pending
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) rowOverride_n <= 1'b1;
        else rowOverride_n <= !(interruptStrobeEn && irqReq);
    end
    always @(posedge sys_clk) lastRow_ff <= memRow;
    // released lines must not look held, so they flip
    assign memRow = microRowOe ? microAddr.row : (!rowOverride_n ? IRQ_ROW : ~lastRow_ff);
endmodule // mps_far_side

// ==== testbench/mps_sequencer_tb.sv ====
// self-checking bench for the microprogram sequencer
`timescale 1ns/1ps
module mps_sequencer_tb;
    import mps_pkg::*;
    logic sys_clk = 0, reset_n = 0, clkEn = 0, loadOverride = 0, flagIn = 0, outEn = 0, irqReq = 0;
    logic [CTRL_W-1:0] nextAddrCtrl = '0;
    mps_flag_ctrl_t flagCtrl = '0;
    logic [3:0] primaryInstrBus = '0, secondaryInstrBus = '0, avs_address = '0, expL, hc;
    logic avs_read = 0, avs_write = 0, expC, expZ, expS, rowOverride_n;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    mps_addr_t microAddr;
    logic microColOe, microRowOe, programLatchOe, flagOut, flagOutOe, interruptStrobeEn, avs_waitrequest;
    logic [2:0] programLatchOut;
    logic [4:0] memRow;
    logic [8:0] expA;
    logic [3:0] fv;
    logic [6:0] corner [4] = '{7'h2f, 7'h78, 7'h70, 7'h7f};
    int errors = 0, n_compared = 0, seed = 60;

    mps_sequencer i_dut (.*);
    mps_far_side i_far (.*);
    initial forever #50 sys_clk = ~sys_clk;

    // ************
    // reference
    // ************
    function automatic logic [8:0] nxa(logic [8:0] m, logic [6:0] a, logic [3:0] l, px, logic c, z, s);
        casez (a)
            7'b00?????: return {a[4:0], m[3:0]};
            7'b010????: return {5'h00, a[3:0]};
            7'b011????: return {m[8:4], a[3:0]};
            7'b100????: return {m[8], a[3:0], m[3], 2'h1, s};
            7'b1010???: return {m[8:7], a[2:0], m[3], 2'h1, c};
            7'b1011???: return {m[8:7], a[2:0], m[3], 2'h1, z};
            7'b1100???: return {m[8:7], a[2:0], l};
            7'b1101???: return {m[8:7], a[2:0], 2'h1, l[3:2]};
            7'b1110???: return {m[8:7], a[2:0], m[3:0]};
            7'b11110??: return {m[8:6], a[1:0], px};
            default:    return {m[8:7], 1'b1, a[1:0], 2'h3, l[1:0]};
        endcase
    endfunction
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {expA, expL, expC, expZ, expS} <= '0;
        end else if (clkEn) begin
            expA <= loadOverride ? {1'b0, secondaryInstrBus, primaryInstrBus}
                : nxa(expA, nextAddrCtrl, expL, primaryInstrBus, expC, expZ, expS);
            if (nextAddrCtrl[6:2] == 5'b11110) expL <= secondaryInstrBus;
            if (!flagCtrl.inSel[0]) expC <= flagIn;
            if (!flagCtrl.inSel[1]) expZ <= flagIn;
            expS <= flagIn;
        end
    end
    assign fv = {1'b1, expZ, expC, 1'b0};

    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    always @(negedge sys_clk) begin
        if (reset_n) begin
            check("addr", microAddr, expA);
            check("rowoe", microRowOe, outEn & rowOverride_n);
            check("coloe", microColOe, outEn);
            check("flagoe", flagOutOe, outEn);
            check("latchoe", programLatchOe, outEn && nextAddrCtrl[6:3] == 4'b1110);
            if (programLatchOe === 1'b1) check("latch", programLatchOut, expL[2:0]);
            check("strobe", interruptStrobeEn, nextAddrCtrl == 7'h2f);
            check("flagout", flagOut, fv[flagCtrl.outSel]);
            if (microRowOe === 1'b1) check("memrow", memRow, expA[8:4]);
        end
    end

    // ************
    // stimulus
    // ************
    task drive(input logic [6:0] c, input logic ld);
        @(posedge sys_clk);
        nextAddrCtrl <= c;
        loadOverride <= ld;
        clkEn <= ($random(seed) % 8) != 0;
        flagCtrl <= 4'($random(seed));
        primaryInstrBus <= 4'($random(seed));
        secondaryInstrBus <= 4'($random(seed));
        flagIn <= 1'($random(seed));
        outEn <= ($random(seed) % 4) != 0;
        irqReq <= 1'($random(seed));
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        @(posedge sys_clk);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
        // values read right at the edge are the settled pre-edge ones
        while (!ok && n < 20) begin
            @(posedge sys_clk);
            n++;
            ok = avs_waitrequest === 1'b0;
        end
        q = avs_readdata;
        if (!ok) errors++;
        {avs_write, avs_read} <= 2'b00;
    endtask
    task stop_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) drive(corner[i % 4], i[2]);
        repeat (300) drive(7'($random(seed)), ($random(seed) % 6) == 0);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (300) drive(7'($random(seed)), ($random(seed) % 6) == 0);
        // park the sequencer so the status word holds still during the reads
        @(negedge sys_clk);
        hc = expA[3:0];
        @(posedge sys_clk);
        {nextAddrCtrl, loadOverride, clkEn, flagIn} <= {3'b011, hc, 3'b011};
        flagCtrl <= '{FLAGOUT_CARRY, FLAGS_HOLD};
        repeat (2) @(posedge sys_clk);
        bus(1'b1, REG_CONTROL, 32'h1, rd);
        bus(1'b0, REG_CONTROL, 32'h0, rd);
        check("control", rd, 32'h1);
        bus(1'b1, 4'h8, 32'hffff_ffff, rd);
        bus(1'b0, 4'h8, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0, rd);
        check("status", rd, {16'h0, expL, expS, expZ, expC, expA});
        stop_test;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        stop_test;
    end
endmodule // mps_sequencer_tb
